// ### design/mcs_pkg.sv
package mcs_pkg;

   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [7:0] MCS_ADDR_TEST = 8'h15;
   localparam logic [7:0] MCS_ADDR_MAKER = 8'h3E;
   localparam logic [7:0] MCS_ADDR_REVISION = 8'h3F;
   localparam logic [7:0] MCS_ADDR_CONFIG = 8'h40;
   localparam logic [7:0] MCS_ADDR_FLAGS_ONE = 8'h41;
   localparam logic [7:0] MCS_ADDR_FLAGS_TWO = 8'h42;
   localparam logic [7:0] MCS_ADDR_VCODE_LOWER = 8'h47;
   localparam logic [7:0] MCS_ADDR_VCODE_FIFTH = 8'h49;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int MCS_CFG_START_BIT = 0;
   localparam int MCS_CFG_PULSE_BIT = 4;
   localparam int MCS_CFG_PINSEL_BIT = 5;
   localparam int MCS_CFG_INIT_BIT = 7;
   localparam int MCS_TEST_SHUTDOWN_BIT = 0;
   localparam int MCS_VCODE_OFFSET_BIT = 6;
   localparam int MCS_VCODE_RSTEN_BIT = 7;
   localparam int MCS_FLAGS2_DIODE_BIT = 6;

   // ****************************************
   // Reset values and masks
   // ****************************************
   localparam logic [7:0] MCS_CONFIG_RESET = 8'h08;
   localparam logic [7:0] MCS_CONFIG_RW_MASK = 8'h31;
   localparam logic [7:0] MCS_FLAGS_RESET = 8'h00;
   localparam logic [7:0] MCS_TEST_RESET = 8'h00;
   localparam logic [1:0] MCS_TEST_RW_MASK = 2'h3;
   localparam logic [7:0] MCS_POINTER_RESET = 8'h00;
   // Identity codes: arbitrary neutral values
   localparam logic [7:0] MCS_MAKER_DEFAULT = 8'h5A;
   localparam logic [7:0] MCS_REVISION_DEFAULT = 8'h11;

   // ****************************************
   // Timing
   // ****************************************
   localparam longint unsigned MCS_SYS_CLK_HZ = 64'd200_000_000;
   localparam longint unsigned MCS_RST_PULSE_MS = 64'd20;
   // Least time, rounded up to whole cycles
   localparam longint unsigned MCS_RST_PULSE_CYCLES =
      (MCS_RST_PULSE_MS * MCS_SYS_CLK_HZ + 64'd999) / 64'd1000;

endpackage

// ### design/mcs_sync.sv
`timescale 1ns/1ps
// ****************************************
// Two-stage synchroniser for pin inputs
// ****************************************
module mcs_sync #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic [WIDTH-1:0] pinIn, // Asynchronous pin levels
   output logic [WIDTH-1:0] syncOut // Synchronised levels
);
   logic [WIDTH-1:0] stageOne_r;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stageOne_r <= '0;
         syncOut <= '0;
      end else begin
         stageOne_r <= pinIn;
         syncOut <= stageOne_r;
      end
   end
endmodule

// ### design/mcs_pulse_gen.sv
`timescale 1ns/1ps
// ****************************************
// Fixed-length low pulse generator
// ****************************************
module mcs_pulse_gen #(
   parameter longint unsigned PULSE_CYCLES = mcs_pkg::MCS_RST_PULSE_CYCLES
) (
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic trigger, // One-cycle start request
   output logic pulseActive // High while pulse runs
);
   logic [31:0] count_r;

   // Retrigger during a pulse is ignored, pulse length stays fixed
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= 32'h0000_0000;
      end else if (count_r != 32'h0000_0000) begin
         count_r <= count_r - 32'h0000_0001;
      end else if (trigger) begin
         count_r <= PULSE_CYCLES[31:0];
      end
   end

   assign pulseActive = (count_r != 32'h0000_0000);
endmodule

// ### design/mcs_regs.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: Start bit cleared puts device in low power with converter disabled.
// RULE2: Voltage-code bit 7 and test bit 0 set power down analog, halt cycle.
// RULE3: Clearing those shutdown bits returns device to its prior state.
// RULE4: Host writes 8-bit pointer selecting register; pointer is write-only.
// RULE5: Configuration register lives at 40h, powers up as 0000 1000.
// RULE6: Start bit 1 begins scanning and limit checks; 0 means standby.
// RULE7: Host should program all limits before setting the start bit.
// RULE8: Configuration bit 4 gives low pulse of 20 ms when reset enabled.
// RULE9: Configuration bit 5 picks pin: 0 is 12 V input, 1 fifth code bit.
// RULE10: Configuration bit 7 restores config and flag defaults, self-clears.
// RULE11: Flags one at 41h resets 00h, read-only, six channel errors.
// RULE12: Flags two at 42h resets 00h, bit0 12 V, bit1 supply error.
// RULE13: Flags two bit 6 reads 1 while remote diode is shorted or open.
// RULE14: The reset pulse request bit clears itself after being set.
// RULE15: Reset output works only when voltage-code bit 7 is 1; default 0.
// RULE16: Writes to read-only or reserved bits are ignored; reserved read 0.
module mcs_regs
   import mcs_pkg::*;
#(
   parameter longint unsigned RST_PULSE_CYCLES = mcs_pkg::MCS_RST_PULSE_CYCLES,
   parameter logic [7:0] MAKER_CODE = mcs_pkg::MCS_MAKER_DEFAULT,
   parameter logic [7:0] REVISION_CODE = mcs_pkg::MCS_REVISION_DEFAULT
) (
   input wire logic sys_clk, // System clock, 200 MHz
   input wire logic rst_n, // Power-on reset, active low
   input wire logic pointerWrite, // Pulse: load pointer from busWrData
   input wire logic regWrite, // Pulse: write busWrData to pointed register
   input wire logic regRead, // Pulse: read pointed register
   input wire logic [7:0] busWrData, // Write data from bus controller
   output logic [7:0] busRdData, // Read data, registered
   output logic busRdValid, // Pulse: busRdData valid
   input wire logic [5:0] limitErrOne, // Pulses: 2.5V,core,3.3V,5V,local,remote
   input wire logic [1:0] limitErrTwo, // Pulses: 12 V, supply
   input wire logic diodeFaultPin, // Async level: remote diode fault
   input wire logic [3:0] voltage_code_low_nibble, // Async code pins
   input wire logic voltage_code_bit_four, // Async fifth code pin
   output logic monitorRun, // Scanning and limit checks active
   output logic converterEnable, // Converter powered and enabled
   output logic analogPowerDown, // All analog circuits off
   output logic pin_function_select, // 0: 12 V input, 1: fifth code bit
   output logic offsetInternal, // Offset applies to local channel
   output logic [1:0] alertSelect, // Test register alert mode bits
   output logic rstPinOut, // Shared reset pin drive level
   output logic rstPinOe_n // Shared reset pin enable, low drives
);
   import mcs_pkg::*;

   // ****************************************
   // Storage
   // ****************************************
   // Operating modes as seen from the outputs
   typedef enum logic [1:0] {
      MODE_STANDBY,
      MODE_RUNNING,
      MODE_SHUTDOWN
   } mcs_mode_t;
   logic [7:0] pointer_r;
   logic [7:0] config_r;
   logic [7:0] flagsOne_r;
   logic [1:0] flagsTwo_r;
   logic [1:0] testBits_r;
   logic offsetCfg_r;
   logic rstEnable_r;
   logic [7:0] rdData_nxt;
   logic [3:0] codeLowSync;
   logic codeFourSync;
   logic diodeFaultSync;
   logic shutdown;
   logic initRequest;
   logic pulseTrigger;
   logic pulseActive;
   logic cfgWrite;
   logic testWrite;
   logic vcodeWrite;
   mcs_mode_t opMode;

   // Pointer target decoding for the write path; the read path decodes pointer_r in its own case
   function automatic logic isAddr(input logic [7:0] ptr, input logic [7:0] addr);
      return ptr == addr;
   endfunction

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Code pins and diode fault come from outside the clock domain
   mcs_sync #(
      .WIDTH(6)
   ) u_pinSync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pinIn({diodeFaultPin, voltage_code_bit_four, voltage_code_low_nibble}),
      .syncOut({diodeFaultSync, codeFourSync, codeLowSync})
   );

   // ****************************************
   // Pointer
   // ****************************************
   // Write-only, no read path exposes it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pointer_r <= MCS_POINTER_RESET;
      end else if (pointerWrite) begin
         pointer_r <= busWrData; // [RULE4]
      end
   end

   // Write decode, one enable for each writable register
   assign cfgWrite = regWrite && isAddr(pointer_r, MCS_ADDR_CONFIG);
   assign testWrite = regWrite && isAddr(pointer_r, MCS_ADDR_TEST);
   assign vcodeWrite = regWrite && isAddr(pointer_r, MCS_ADDR_VCODE_LOWER);

   // Initialization request: a write of 1 into bit 7
   assign initRequest = cfgWrite && busWrData[MCS_CFG_INIT_BIT];

   // ****************************************
   // Configuration register
   // ****************************************
   // Init bit is never stored, so it always reads 0; pulse bit drops
   // one cycle after it is set, the pulse generator has sampled it by then
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         config_r <= MCS_CONFIG_RESET; // [RULE5]
      end else if (initRequest) begin
         config_r <= MCS_CONFIG_RESET; // [RULE10]
      end else if (cfgWrite) begin
         config_r <= (busWrData & MCS_CONFIG_RW_MASK)
            | (MCS_CONFIG_RESET & ~MCS_CONFIG_RW_MASK); // [RULE16]
      end else if (config_r[MCS_CFG_PULSE_BIT]) begin
         config_r[MCS_CFG_PULSE_BIT] <= 1'b0; // [RULE14]
      end
   end

   // ****************************************
   // Test register and voltage-code control bits
   // ****************************************
   // Only the two function bits are kept; upper bits must be written 0
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         testBits_r <= MCS_TEST_RESET[1:0];
      end else if (testWrite) begin
         testBits_r <= busWrData[1:0] & MCS_TEST_RW_MASK;
      end
   end

   // Init leaves these alone; power-on clears them, a write to 47h loads them from bits 6 and 7
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         offsetCfg_r <= 1'b0;
         rstEnable_r <= 1'b0; // [RULE15]
      end else if (vcodeWrite) begin
         offsetCfg_r <= busWrData[MCS_VCODE_OFFSET_BIT];
         rstEnable_r <= busWrData[MCS_VCODE_RSTEN_BIT];
      end
   end

   // ****************************************
   // Limit error flags
   // ****************************************
   // Sticky; an error in the init cycle survives, set beats clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flagsOne_r <= MCS_FLAGS_RESET; // [RULE11]
      end else if (initRequest) begin
         flagsOne_r <= {2'b00, limitErrOne}; // [RULE10]
      end else begin
         flagsOne_r <= flagsOne_r | {2'b00, limitErrOne}; // [RULE11]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flagsTwo_r <= MCS_FLAGS_RESET[1:0]; // [RULE12]
      end else if (initRequest) begin
         flagsTwo_r <= limitErrTwo; // [RULE10]
      end else begin
         flagsTwo_r <= flagsTwo_r | limitErrTwo; // [RULE12]
      end
   end

   // ****************************************
   // Operating state
   // ****************************************
   // Shutdown only gates outputs; start bit is untouched so the
   // device picks up where it was once shutdown bits clear
   assign shutdown = rstEnable_r && testBits_r[MCS_TEST_SHUTDOWN_BIT]; // [RULE2]

   // Shutdown outranks the start bit, registers stay as they are
   always_comb begin
      if (shutdown) begin
         opMode = MODE_SHUTDOWN; // [RULE2]
      end else if (config_r[MCS_CFG_START_BIT]) begin
         opMode = MODE_RUNNING; // [RULE6] [RULE3]
      end else begin
         opMode = MODE_STANDBY; // [RULE1]
      end
   end

   // Converter and scan enables for each mode
   always_comb begin
      monitorRun = 1'b0;
      converterEnable = 1'b0;
      analogPowerDown = 1'b0;
      case (opMode)
         MODE_STANDBY: begin
            monitorRun = 1'b0; // [RULE1]
            converterEnable = 1'b0; // [RULE1]
            analogPowerDown = 1'b0;
         end
         MODE_RUNNING: begin
            monitorRun = 1'b1; // [RULE6]
            converterEnable = 1'b1; // [RULE6]
            analogPowerDown = 1'b0;
         end
         MODE_SHUTDOWN: begin
            monitorRun = 1'b0; // [RULE2]
            converterEnable = 1'b0; // [RULE2]
            analogPowerDown = 1'b1; // [RULE2]
         end
         default: begin
            monitorRun = 1'b0;
            converterEnable = 1'b0;
            analogPowerDown = 1'b0;
         end
      endcase
   end

   // Pin mode and test function levels
   assign pin_function_select = config_r[MCS_CFG_PINSEL_BIT]; // [RULE9]
   assign offsetInternal = offsetCfg_r && testBits_r[0] && !rstEnable_r;
   assign alertSelect = testBits_r;

   // ****************************************
   // Reset pulse on the shared pin
   // ****************************************
   // Request without reset enable is dropped, not queued
   assign pulseTrigger = config_r[MCS_CFG_PULSE_BIT] && rstEnable_r; // [RULE8] [RULE15]

   mcs_pulse_gen #(
      .PULSE_CYCLES(RST_PULSE_CYCLES)
   ) u_rstPulse (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .trigger(pulseTrigger),
      .pulseActive(pulseActive)
   );

   // Open drain: drive low only during the pulse
   assign rstPinOut = 1'b0;
   assign rstPinOe_n = !pulseActive; // [RULE8]

   // ****************************************
   // Read path
   // ****************************************
   // Unmapped and write-only addresses read 00h
   always_comb begin
      rdData_nxt = 8'h00;
      case (pointer_r)
         MCS_ADDR_TEST: begin
            rdData_nxt = {6'b00_0000, testBits_r};
         end
         MCS_ADDR_MAKER: begin
            rdData_nxt = MAKER_CODE;
         end
         MCS_ADDR_REVISION: begin
            rdData_nxt = REVISION_CODE;
         end
         MCS_ADDR_CONFIG: begin
            rdData_nxt = config_r;
         end
         MCS_ADDR_FLAGS_ONE: begin
            rdData_nxt = flagsOne_r; // [RULE11]
         end
         MCS_ADDR_FLAGS_TWO: begin
            rdData_nxt = {1'b0, diodeFaultSync, 4'h0, flagsTwo_r}; // [RULE13] [RULE16]
         end
         MCS_ADDR_VCODE_LOWER: begin
            rdData_nxt = {rstEnable_r, offsetCfg_r, 2'b00, codeLowSync};
         end
         MCS_ADDR_VCODE_FIFTH: begin
            // Fifth code bit only when the pin is in digital mode
            rdData_nxt = {7'h00, codeFourSync && pin_function_select}; // [RULE9]
         end
         default: begin
            rdData_nxt = 8'h00;
         end
      endcase
   end

   // Data registered one cycle after the read strobe
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busRdData <= 8'h00;
         busRdValid <= 1'b0;
      end else begin
         busRdValid <= regRead;
         if (regRead) begin
            busRdData <= rdData_nxt;
         end
      end
   end

endmodule

// ### tb/mcs_regs_assertions.sv
`timescale 1ns/1ps
module mcs_regs_checker #(
   parameter longint unsigned RST_PULSE_CYCLES = 64'd20
) (
   input wire logic sys_clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic regWrite, // Write strobe
   input wire logic regRead, // Read strobe
   input wire logic [7:0] busRdData, // Read data
   input wire logic busRdValid, // Read valid
   input wire logic monitorRun, // Scan active
   input wire logic converterEnable, // Converter on
   input wire logic analogPowerDown, // Analog off
   input wire logic pin_function_select, // Pin mode
   input wire logic rstPinOut, // Pin level
   input wire logic rstPinOe_n // Pin enable, low drives
);
   logic [63:0] lowCnt_r;
   // Length of the present drive; a counter, as the pulse is too long to unroll
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) lowCnt_r <= 64'h0;
      else if (!rstPinOe_n) lowCnt_r <= lowCnt_r + 64'h1;
      else lowCnt_r <= 64'h0;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ****************************************
   // Properties
   // ****************************************
   sequence s_readAnswer;
      regRead ##1 busRdValid;
   endsequence
   property p_readAnswer; regRead |-> s_readAnswer; endproperty
   property p_noStrayValid; !regRead |=> !busRdValid; endproperty
   property p_dataHeld; !busRdValid |-> $stable(busRdData); endproperty
   property p_shutdownHalts; analogPowerDown |-> !monitorRun && !converterEnable; endproperty
   property p_pinLow; !rstPinOe_n |-> !rstPinOut; endproperty
   property p_pulseLength; $rose(rstPinOe_n) |-> lowCnt_r == RST_PULSE_CYCLES; endproperty
   property p_pulseCause; $fell(rstPinOe_n) |-> $past(regWrite, 2); endproperty
   property p_powerCause; $changed(analogPowerDown) |-> $past(regWrite); endproperty
   property p_runCause; $changed(monitorRun) |-> $past(regWrite); endproperty
   property p_pinCause; $changed(pin_function_select) |-> $past(regWrite); endproperty
   a_readAnswer: assert property (p_readAnswer) else $error("read not answered");
   a_noStrayValid: assert property (p_noStrayValid) else $error("stray valid");
   a_dataHeld: assert property (p_dataHeld) else $error("read data moved");
   a_shutdownHalts: assert property (p_shutdownHalts) else $error("runs in shutdown");
   a_pinLow: assert property (p_pinLow) else $error("pin not driven low");
   a_pulseLength: assert property (p_pulseLength) else $error("pulse length");
   a_pulseCause: assert property (p_pulseCause) else $error("pulse uncaused");
   a_powerCause: assert property (p_powerCause) else $error("power moved");
   a_runCause: assert property (p_runCause) else $error("run moved");
   a_pinCause: assert property (p_pinCause) else $error("pin mode moved");
endmodule

bind mcs_regs mcs_regs_checker #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) u_checker (
   .sys_clk(sys_clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
   .busRdData(busRdData), .busRdValid(busRdValid), .monitorRun(monitorRun),
   .converterEnable(converterEnable), .analogPowerDown(analogPowerDown),
   .pin_function_select(pin_function_select), .rstPinOut(rstPinOut), .rstPinOe_n(rstPinOe_n));

// ### tb/mcs_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Bus controller side of the register port
// ****************************************
module mcs_host_model (
   input wire logic sys_clk, // Clock
   output logic pointerWrite, // Pointer strobe
   output logic regWrite, // Write strobe
   output logic regRead, // Read strobe
   output logic [7:0] busWrData, // Write data
   input wire logic [7:0] busRdData, // Read data
   input wire logic busRdValid // Read valid
);
   // Idle strobes; data shows the inverse of the last byte once released
   initial begin
      pointerWrite = 1'b0;
      regWrite = 1'b0;
      regRead = 1'b0;
      busWrData = 8'h00;
   end
   // Pointer cycle, then one data cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      pointerWrite <= 1'b1;
      busWrData <= a;
      @(posedge sys_clk);
      pointerWrite <= 1'b0;
      regWrite <= 1'b1;
      busWrData <= d;
      @(posedge sys_clk);
      regWrite <= 1'b0;
      busWrData <= ~d;
   endtask
   // Pointer cycle, read strobe, answer one edge later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      pointerWrite <= 1'b1;
      busWrData <= a;
      @(posedge sys_clk);
      pointerWrite <= 1'b0;
      busWrData <= ~a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      @(posedge sys_clk);
      d = (busRdValid === 1'b1) ? busRdData : 8'hxx;
   endtask
endmodule

// ### tb/tb_monitor_control_status_regs.sv
`timescale 1ns/1ps
module tb_monitor_control_status_regs;
   import mcs_pkg::*;
   logic sys_clk = 1'b0, rst_n = 1'b0, pointerWrite, regWrite, regRead, busRdValid;
   logic [7:0] busWrData, busRdData;
   logic [5:0] limitErrOne = 6'h00;
   logic [1:0] limitErrTwo = 2'h0, alertSelect;
   logic diodeFaultPin = 1'b0, voltage_code_bit_four = 1'b0;
   logic [3:0] voltage_code_low_nibble = 4'h0;
   logic monitorRun, converterEnable, analogPowerDown, pin_function_select;
   logic offsetInternal, rstPinOut, rstPinOe_n, rstWire;
   int failures = 0, testsRun = 0, n, w;
   // Pin has a pull-up while released
   assign rstWire = rstPinOe_n ? 1'b1 : rstPinOut;
   always #2.5 sys_clk = ~sys_clk;
   mcs_host_model host (.sys_clk(sys_clk), .pointerWrite(pointerWrite), .regWrite(regWrite),
      .regRead(regRead), .busWrData(busWrData), .busRdData(busRdData), .busRdValid(busRdValid));
   mcs_regs #(.RST_PULSE_CYCLES(64'd20)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .pointerWrite(pointerWrite), .regWrite(regWrite), .regRead(regRead),
      .busWrData(busWrData), .busRdData(busRdData), .busRdValid(busRdValid),
      .limitErrOne(limitErrOne), .limitErrTwo(limitErrTwo), .diodeFaultPin(diodeFaultPin),
      .voltage_code_low_nibble(voltage_code_low_nibble),
      .voltage_code_bit_four(voltage_code_bit_four), .monitorRun(monitorRun),
      .converterEnable(converterEnable), .analogPowerDown(analogPowerDown),
      .pin_function_select(pin_function_select), .offsetInternal(offsetInternal),
      .alertSelect(alertSelect), .rstPinOut(rstPinOut), .rstPinOe_n(rstPinOe_n));
   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      testsRun++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Whole sequence needs under two hundred cycles
   initial begin
      #100000;
      failures++;
      test_done();
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      rchk(MCS_ADDR_CONFIG, 8'h08);
      rchk(MCS_ADDR_FLAGS_ONE, 8'h00);
      rchk(MCS_ADDR_FLAGS_TWO, 8'h00);
      // No limit registers here, so start comes first
      host.wr(MCS_ADDR_CONFIG, 8'h01);
      #1 chk({converterEnable, monitorRun}, 8'h03);
      host.wr(MCS_ADDR_CONFIG, 8'h00);
      #1 chk({converterEnable, monitorRun}, 8'h00);
      host.wr(MCS_ADDR_FLAGS_ONE, 8'hFF);
      rchk(MCS_ADDR_FLAGS_ONE, 8'h00);
      rchk(8'h50, 8'h00);
      // One-cycle error pulses must stick
      @(posedge sys_clk);
      limitErrOne <= 6'h3F;
      limitErrTwo <= 2'h3;
      diodeFaultPin <= 1'b1;
      @(posedge sys_clk);
      limitErrOne <= 6'h00;
      limitErrTwo <= 2'h0;
      voltage_code_low_nibble <= 4'hA;
      voltage_code_bit_four <= 1'b1;
      rchk(MCS_ADDR_FLAGS_ONE, 8'h3F);
      rchk(MCS_ADDR_FLAGS_TWO, 8'h43);
      host.wr(MCS_ADDR_CONFIG, 8'h81);
      rchk(MCS_ADDR_CONFIG, 8'h08);
      rchk(MCS_ADDR_FLAGS_ONE, 8'h00);
      rchk(MCS_ADDR_FLAGS_TWO, 8'h40);
      host.wr(MCS_ADDR_CONFIG, 8'h21);
      #1 chk({pin_function_select, monitorRun}, 8'h03);
      rchk(MCS_ADDR_VCODE_LOWER, 8'h0A);
      rchk(MCS_ADDR_VCODE_FIFTH, 8'h01);
      host.wr(MCS_ADDR_VCODE_LOWER, 8'h80);
      host.wr(MCS_ADDR_TEST, 8'h01);
      #1 chk({analogPowerDown, monitorRun}, 8'h02);
      rchk(MCS_ADDR_CONFIG, 8'h29);
      host.wr(MCS_ADDR_TEST, 8'h00);
      #1 chk({analogPowerDown, monitorRun}, 8'h01);
      // Pulse request with the pin function enabled
      host.wr(MCS_ADDR_CONFIG, 8'h31);
      n = 0;
      w = 0;
      while (rstWire === 1'b1 && w < 10) begin
         @(posedge sys_clk);
         w++;
      end
      while (rstWire === 1'b0 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      chk(8'(n), 8'h14);
      rchk(MCS_ADDR_CONFIG, 8'h29);
      // Same request with the pin function disabled
      host.wr(MCS_ADDR_VCODE_LOWER, 8'h00);
      host.wr(MCS_ADDR_CONFIG, 8'h11);
      n = 0;
      repeat (30) begin
         @(posedge sys_clk);
         if (rstWire !== 1'b1) n++;
      end
      chk(8'(n), 8'h00);
      // Offset routing and alert bits; no shutdown while reset enable is clear
      host.wr(MCS_ADDR_VCODE_LOWER, 8'h40);
      host.wr(MCS_ADDR_TEST, 8'h03);
      #1 chk({offsetInternal, alertSelect, analogPowerDown}, 8'h0E);
      rchk(MCS_ADDR_TEST, 8'h03);
      rchk(MCS_ADDR_VCODE_LOWER, 8'h4A);
      host.wr(MCS_ADDR_MAKER, 8'h00);
      rchk(MCS_ADDR_MAKER, MCS_MAKER_DEFAULT);
      test_done();
   end
endmodule
